// file: core/bcht_config_tail.v
// bridge configuration header tail: io top, capability pointer, interrupt regs, bridge control
//
// Functional notes
// - io window top field gives address bits 31:20; low 20 bits taken as ones.
// - capability pointer is read-only and always reads 50h.
// - interrupt line register resets to FFh, meaning unassigned.
// - interrupt line is plain read/write storage steering nothing.
// - interrupt pin register is read-only and reads 00h.
// - secondary interrupts are passed through to the primary side.
// - bridge control bits 15:12 ignore writes and read zero.
// - with enable bit 11 set, each discard sends an error message upstream.
// - discard error messages only apply in conventional PCI mode.
// - message is nonfatal by default; fatal only with advanced error reporting.
// - enable clear still sends if advanced reporting present and mask bit 10 clear.
// - hardware sets bridge control bit 10 on every discard.
// - bit 9 picks 2^15 (zero) or 2^10 (one) clocks, counted from queue head.
// - unrepeated delayed request is removed from queue and status bit set.
`timescale 1ns/1ns
`default_nettype none
`include "bcht_regs.vh"

module bcht_config_tail #(
	parameter AER_SUPPORTED = 1'b1,
	parameter LONG_CYCLES   = `BCHT_DISCARD_LONG,
	parameter SHORT_CYCLES  = `BCHT_DISCARD_SHORT
) (
	input  wire        CLK_IN,
	input  wire        NRST_IN,
	// configuration access port, dword wide, one request per pulse
	input  wire [7:0]  CFG_ADDR_IN,
	input  wire        CFG_RD_IN,
	input  wire        CFG_WR_IN,
	input  wire [3:0]  CFG_BE_IN,
	input  wire [31:0] CFG_WDATA_IN,
	output reg  [31:0] CFG_RDATA_OUT,
	output reg         CFG_ACK_OUT,
	// io forwarding check
	input  wire        IO_REQ_IN,
	input  wire [31:0] IO_ADDR_IN,
	output reg         IO_FWD_VALID_OUT,
	output reg         IO_BELOW_TOP_OUT,
	// delayed transaction queue
	input  wire        DC_HEAD_VALID_IN,
	input  wire        DC_REPEAT_IN,
	output wire        DC_DISCARD_OUT,
	// error reporting context
	input  wire        CONV_PCI_MODE_IN,
	input  wire        SEC_UE_MASK_DISCARD_IN,
	input  wire        SEC_UE_SEVERITY_FATAL_IN,
	output reg         ERR_NONFATAL_OUT,
	output reg         ERR_FATAL_OUT,
	// interrupt pass-through, active low
	input  wire [3:0]  SEC_INT_N_IN,
	output reg  [3:0]  PRI_INT_N_OUT
);

	// registers
	reg  [15:0] io_window_top_bits;
	reg  [7:0]  interrupt_line_scratch;
	reg         discard_error_msg_enable;
	reg         discard_timeout_flag;
	reg         secondary_discard_period_select;
	reg  [3:0]  int_sync_a;
	reg  [3:0]  int_sync_b;
	reg  [31:0] next_rdata;
	wire [5:0]  dw_addr;
	wire        hit_io_upper;
	wire        hit_cap_ptr;
	wire        hit_int_bridge;
	wire        wr_int_bridge;
	wire        flag_clear;
	wire        send_msg;
	wire [15:0] bridge_control;
	wire [31:0] io_top_addr;

	// byte-lane merge used by the io top and interrupt line bytes
	function [7:0] merge_byte;
		input [7:0] old_val;
		input [7:0] new_val;
		input       lane_en;
		begin
			merge_byte = lane_en ? new_val : old_val;
		end
	endfunction

	// dword decode; the two low address bits select no register
	assign dw_addr        = CFG_ADDR_IN[7:2];
	assign hit_io_upper   = (dw_addr == `BCHT_DW_IO_UPPER);
	assign hit_cap_ptr    = (dw_addr == `BCHT_DW_CAP_PTR);
	assign hit_int_bridge = (dw_addr == `BCHT_DW_INT_BRIDGE);
	assign wr_int_bridge  = CFG_WR_IN && hit_int_bridge;

	// write of one clears the flag, zero leaves it
	assign flag_clear = wr_int_bridge && CFG_BE_IN[3] &&
		CFG_WDATA_IN[16 + `BCHT_BC_TIMEOUT_FLAG];

	// assembled bridge control; unimplemented low bits and reserved top read zero
	assign bridge_control = {4'h0,
		discard_error_msg_enable,
		discard_timeout_flag,
		secondary_discard_period_select,
		9'h000};

	// top of io window: field supplies 31:20, the rest all ones
	assign io_top_addr = {io_window_top_bits[`BCHT_IO_TOP_FIELD_MSB:0], `BCHT_IO_TOP_LOW_ONES};

	// discard timer, runs on the bridge clock
	bcht_discard_timer #(
		.LONG_CYCLES    (LONG_CYCLES),
		.SHORT_CYCLES   (SHORT_CYCLES)
	) u_timer (
		.clk_in          (CLK_IN),
		.nrst_in         (NRST_IN),
		.head_valid_in   (DC_HEAD_VALID_IN),
		.repeat_in       (DC_REPEAT_IN),
		.short_select_in (secondary_discard_period_select),
		.expire_out      (DC_DISCARD_OUT)
	);

	// message decision: enable bit, or unmasked under advanced reporting, only in conventional mode
	assign send_msg = DC_DISCARD_OUT && CONV_PCI_MODE_IN &&
		(discard_error_msg_enable ||
		 (AER_SUPPORTED && !SEC_UE_MASK_DISCARD_IN));

	// configuration writes; read-only bytes simply have no storage
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			io_window_top_bits              <= `BCHT_RST_IO_TOP_UPPER;
			interrupt_line_scratch          <= `BCHT_RST_INT_LINE;
			discard_error_msg_enable        <= 1'b0;
			secondary_discard_period_select <= 1'b0;
		end else if (CFG_WR_IN) begin
			if (hit_io_upper) begin
				io_window_top_bits[7:0]  <= merge_byte(io_window_top_bits[7:0], CFG_WDATA_IN[23:16], CFG_BE_IN[2]);
				io_window_top_bits[15:8] <= merge_byte(io_window_top_bits[15:8], CFG_WDATA_IN[31:24], CFG_BE_IN[3]);
			end else if (hit_int_bridge) begin
				// scratch byte, read back only
				interrupt_line_scratch <= merge_byte(interrupt_line_scratch, CFG_WDATA_IN[7:0], CFG_BE_IN[0]);
				if (CFG_BE_IN[3])
					discard_error_msg_enable <= CFG_WDATA_IN[16 + `BCHT_BC_MSG_ENABLE];
				if (CFG_BE_IN[3])
					secondary_discard_period_select <= CFG_WDATA_IN[16 + `BCHT_BC_PERIOD_SELECT];
			end
		end
	end

	// bridge control bits 11:9 all sit in byte lane 3 of the dword

	// sticky discard flag; a discard in the clearing cycle keeps it set
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN)
			discard_timeout_flag <= 1'b0;
		else if (DC_DISCARD_OUT)
			discard_timeout_flag <= 1'b1;
		else if (flag_clear)
			discard_timeout_flag <= 1'b0;
	end

	// read mux; unmapped dwords read zero
	always @* begin
		next_rdata = 32'h0000_0000;
		if (hit_io_upper)
			next_rdata = {io_window_top_bits, 16'h0000};
		else if (hit_cap_ptr)
			next_rdata = {24'h00_0000, `BCHT_VAL_CAP_PTR};
		else if (hit_int_bridge)
			next_rdata = {bridge_control, `BCHT_VAL_INT_PIN, interrupt_line_scratch};
	end

	// one-cycle acknowledge for reads and writes; read data loaded only on reads
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			CFG_RDATA_OUT <= 32'h0000_0000;
			CFG_ACK_OUT   <= 1'b0;
		end else begin
			CFG_ACK_OUT <= CFG_RD_IN || CFG_WR_IN;
			if (CFG_RD_IN)
				CFG_RDATA_OUT <= next_rdata;
		end
	end

	// io forward compare against the window top
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			IO_FWD_VALID_OUT <= 1'b0;
			IO_BELOW_TOP_OUT <= 1'b0;
		end else begin
			IO_FWD_VALID_OUT <= IO_REQ_IN;
			if (IO_REQ_IN)
				IO_BELOW_TOP_OUT <= (IO_ADDR_IN <= io_top_addr);
		end
	end

	// error message pulses; fatal only chosen under advanced reporting
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ERR_NONFATAL_OUT <= 1'b0;
			ERR_FATAL_OUT    <= 1'b0;
		end else begin
			ERR_FATAL_OUT    <= send_msg && AER_SUPPORTED && SEC_UE_SEVERITY_FATAL_IN;
			ERR_NONFATAL_OUT <= send_msg && !(AER_SUPPORTED && SEC_UE_SEVERITY_FATAL_IN);
		end
	end

	// interrupt pins come from the secondary bus: two synchroniser flops, then an output flop
	always @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			int_sync_a    <= 4'hF;
			int_sync_b    <= 4'hF;
			PRI_INT_N_OUT <= 4'hF;
		end else begin
			int_sync_a    <= SEC_INT_N_IN;
			int_sync_b    <= int_sync_a;
			PRI_INT_N_OUT <= int_sync_b;
		end
	end

endmodule

`default_nettype wire

// file: core/bcht_discard_timer.v
// secondary discard timer for the delayed completion at the head of the downstream queue
`timescale 1ns/1ns
`default_nettype none
`include "bcht_regs.vh"

module bcht_discard_timer #(
	parameter LONG_CYCLES  = `BCHT_DISCARD_LONG,
	parameter SHORT_CYCLES = `BCHT_DISCARD_SHORT
) (
	input  wire        clk_in,
	input  wire        nrst_in,
	input  wire        head_valid_in,
	input  wire        repeat_in,
	input  wire        short_select_in,
	output reg         expire_out
);

	localparam ST_IDLE  = 2'b00;
	localparam ST_COUNT = 2'b01;
	localparam ST_DONE  = 2'b10;

	reg  [1:0]  state;
	reg  [15:0] count;
	reg  [1:0]  next_state;
	wire [15:0] limit;

	// the select is sampled every cycle, so changing it mid-count moves the end point
	assign limit = short_select_in ? SHORT_CYCLES[15:0] - 16'h0001 : LONG_CYCLES[15:0] - 16'h0001;

	// idle until a completion reaches the head, count until repeat or expiry
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (head_valid_in && !repeat_in)
				next_state = ST_COUNT;
		end
		ST_COUNT: begin
			if (repeat_in || !head_valid_in)
				next_state = ST_IDLE;
			else if (count >= limit)
				next_state = ST_DONE;
		end
		default: begin
			// wait for the queue to drop the entry before arming again
			if (!head_valid_in)
				next_state = ST_IDLE;
		end
		endcase
	end

	// counter starts with the head entry; one expiry pulse per entry
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state      <= ST_IDLE;
			count      <= 16'h0000;
			expire_out <= 1'b0;
		end else begin
			state      <= next_state;
			expire_out <= (state == ST_COUNT) && (next_state == ST_DONE);
			if (state == ST_COUNT)
				count <= count + 16'h0001;
			else
				count <= 16'h0000;
		end
	end

endmodule

`default_nettype wire

// file: include/bcht_regs.vh
// configuration header tail: offsets, field positions, reset values and timer counts
`ifndef BCHT_REGS_VH
`define BCHT_REGS_VH

// printed byte offsets of each register
`define BCHT_OFF_IO_TOP_UPPER   8'h32
`define BCHT_OFF_CAP_PTR        8'h34
`define BCHT_OFF_INT_LINE       8'h3C
`define BCHT_OFF_INT_PIN        8'h3D
`define BCHT_OFF_BRIDGE_CTRL    8'h3E

// dword addresses holding those registers
`define BCHT_DW_IO_UPPER        6'h0C
`define BCHT_DW_CAP_PTR         6'h0D
`define BCHT_DW_INT_BRIDGE      6'h0F

// reset and hardwired values
`define BCHT_RST_IO_TOP_UPPER   16'h0000
`define BCHT_VAL_CAP_PTR        8'h50
`define BCHT_RST_INT_LINE       8'hFF
`define BCHT_VAL_INT_PIN        8'h00
`define BCHT_RST_BRIDGE_CTRL    16'h0000

// io window top: field bits that form address bits 31:20, low bits forced to ones
`define BCHT_IO_TOP_FIELD_MSB   11
`define BCHT_IO_TOP_LOW_ONES    20'hF_FFFF

// bridge control field positions
`define BCHT_BC_RSVD_MSB        15
`define BCHT_BC_RSVD_LSB        12
`define BCHT_BC_MSG_ENABLE      11
`define BCHT_BC_TIMEOUT_FLAG    10
`define BCHT_BC_PERIOD_SELECT   9

// discard timer lengths in bridge clocks, as powers of two
`define BCHT_DISCARD_LONG_EXP   15
`define BCHT_DISCARD_SHORT_EXP  10
`define BCHT_DISCARD_LONG       32768
`define BCHT_DISCARD_SHORT      1024

`endif

// file: sim/bcht_host.sv
// upstream host model issuing single configuration accesses
`timescale 1ns/1ns
`default_nettype none
module bcht_host (
	input  wire logic        clk,
	input  wire logic [31:0] rdata,
	input  wire logic        ack,
	output logic [7:0]       addr = 8'h00,
	output logic             rd = 1'b0,
	output logic             wr = 1'b0,
	output logic [3:0]       be = 4'h0,
	output logic [31:0]      wdata = 32'h0000_0000
);
	// request held across one rising edge, answer taken in the following cycle
	task xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		@(negedge clk);
		{addr, be, wdata, rd, wr} = {a, b, d, !w, w};
		@(posedge clk);
		@(negedge clk);
		{q, ok} = {rdata, ack};
		// released address and data lines carry the inverse so a stale value can never match
		{addr, be, wdata, rd, wr} = {~a, 4'h0, ~d, 2'b00};
	endtask
endmodule
`default_nettype wire

// file: sim/bcht_tail_monitor.sv
// concurrent checks on the configuration header tail ports
`timescale 1ns/1ns
`default_nettype none
module bcht_tail_monitor (
	input wire logic        CLK_IN,
	input wire logic        NRST_IN,
	input wire logic [7:0]  CFG_ADDR_IN,
	input wire logic        CFG_RD_IN,
	input wire logic [31:0] CFG_RDATA_OUT,
	input wire logic        IO_REQ_IN,
	input wire logic        IO_FWD_VALID_OUT,
	input wire logic        DC_HEAD_VALID_IN,
	input wire logic        DC_REPEAT_IN,
	input wire logic        DC_DISCARD_OUT,
	input wire logic        CONV_PCI_MODE_IN,
	input wire logic        SEC_UE_MASK_DISCARD_IN,
	input wire logic        SEC_UE_SEVERITY_FATAL_IN,
	input wire logic        ERR_NONFATAL_OUT,
	input wire logic        ERR_FATAL_OUT,
	input wire logic [3:0]  SEC_INT_N_IN,
	input wire logic [3:0]  PRI_INT_N_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// reads of the hardwired places must return fixed values whatever was written
	property p_cap; CFG_RD_IN && CFG_ADDR_IN[7:2] == 6'h0D |=> CFG_RDATA_OUT == 32'h0000_0050; endproperty
	a_cap: assert property (p_cap) else $error("pointer wrong");
	property p_pin; CFG_RD_IN && CFG_ADDR_IN[7:2] == 6'h0F |=> CFG_RDATA_OUT[31:28] == 4'h0 && CFG_RDATA_OUT[15:8] == 8'h00; endproperty
	a_pin: assert property (p_pin) else $error("pin or reserved nonzero");
	property p_fwd; IO_REQ_IN |=> IO_FWD_VALID_OUT; endproperty
	a_fwd: assert property (p_fwd) else $error("io check missing");
	// three-edge pass-through, so a dropped synchroniser stage shows up
	property p_int; PRI_INT_N_OUT == $past(SEC_INT_N_IN, 3); endproperty
	a_int: assert property (p_int) else $error("interrupt not forwarded");
	property p_mode; ERR_NONFATAL_OUT || ERR_FATAL_OUT |-> $past(DC_DISCARD_OUT) && $past(CONV_PCI_MODE_IN); endproperty
	a_mode: assert property (p_mode) else $error("stray error message");
	property p_send; DC_DISCARD_OUT && CONV_PCI_MODE_IN && !SEC_UE_MASK_DISCARD_IN |=> ERR_NONFATAL_OUT || ERR_FATAL_OUT; endproperty
	a_send: assert property (p_send) else $error("unmasked discard silent");
	property p_sev; ERR_FATAL_OUT |-> $past(SEC_UE_SEVERITY_FATAL_IN) && !ERR_NONFATAL_OUT; endproperty
	a_sev: assert property (p_sev) else $error("wrong severity");
	property p_drop; DC_DISCARD_OUT |-> $past(DC_HEAD_VALID_IN) && !$past(DC_REPEAT_IN); endproperty
	a_drop: assert property (p_drop) else $error("discard without head");
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the configuration header tail
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        clk = 1'b0, nrst = 1'b0, rd, wr, ack, ioreq = 1'b0, bt, fv, disc, enf, ef;
	logic        head = 1'b0, rpt = 1'b0, mode = 1'b1, mask = 1'b0, fat = 1'b0;
	logic [3:0]  be, pi, si = 4'hF;
	logic [7:0]  addr;
	logic [31:0] wd, rdat, ioa = 32'h0000_0000;
	int          err_count = 0, tests_run = 0, cyc = 0;
	bcht_host host (.clk(clk), .rdata(rdat), .ack(ack), .addr(addr), .rd(rd), .wr(wr), .be(be), .wdata(wd));
	// short timer lengths keep the run brief; expectations use the same figures
	bcht_config_tail #(.LONG_CYCLES(40), .SHORT_CYCLES(16)) dut (.CLK_IN(clk), .NRST_IN(nrst),
		.CFG_ADDR_IN(addr), .CFG_RD_IN(rd), .CFG_WR_IN(wr), .CFG_BE_IN(be), .CFG_WDATA_IN(wd),
		.CFG_RDATA_OUT(rdat), .CFG_ACK_OUT(ack), .IO_REQ_IN(ioreq), .IO_ADDR_IN(ioa), .IO_FWD_VALID_OUT(fv),
		.IO_BELOW_TOP_OUT(bt), .DC_HEAD_VALID_IN(head), .DC_REPEAT_IN(rpt), .DC_DISCARD_OUT(disc),
		.CONV_PCI_MODE_IN(mode), .SEC_UE_MASK_DISCARD_IN(mask), .SEC_UE_SEVERITY_FATAL_IN(fat),
		.ERR_NONFATAL_OUT(enf), .ERR_FATAL_OUT(ef), .SEC_INT_N_IN(si), .PRI_INT_N_OUT(pi));
	always #5 clk = ~clk;
	// hang guard: the sequence needs some 260 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			summarize();
		end
	end
	task summarize();
		$display("mismatches %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one access; for a read d is the expected data
	task acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		logic [31:0] q;
		logic        ok;
		host.xfer(w, a, b, d, q, ok);
		check(ok, 1);
		if (!w)
			check(q, d);
	endtask
	task iochk(input logic [31:0] a, input logic e);
		@(negedge clk);
		{ioa, ioreq} = {a, 1'b1};
		@(negedge clk);
		{ioa, ioreq} = {~a, 1'b0};
		check(bt, e);
	endtask
	// hold a completion at the queue head until it is dropped, then look at the message pair
	task run_disc(input int n, input logic [1:0] e);
		int k;
		k = 0;
		@(negedge clk);
		head = 1;
		while (disc !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		check(k >= n && k <= n + 3, 1);
		@(negedge clk);
		head = 0;
		check({enf, ef}, e);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		nrst = 1;
		acc(0, 8'h30, 4'hF, 32'h0000_0000);
		acc(0, 8'h3C, 4'hF, 32'h0000_00FF);
		acc(1, 8'h34, 4'hF, 32'hFFFF_FFFF);
		acc(0, 8'h34, 4'hF, 32'h0000_0050);
		acc(1, 8'h30, 4'hF, 32'h0012_FFFF);
		acc(0, 8'h30, 4'hF, 32'h0012_0000);
		iochk(32'h012F_FFFF, 1);
		iochk(32'h0130_0000, 0);
		acc(1, 8'h3C, 4'hF, 32'hFFFF_FF5A);
		acc(0, 8'h3C, 4'hF, 32'h0A00_005A);
		run_disc(16, 2'b10);
		acc(0, 8'h3C, 4'hF, 32'h0E00_005A);
		acc(1, 8'h3C, 4'hC, 32'h0000_0000);
		acc(0, 8'h3C, 4'hF, 32'h0400_005A);
		acc(1, 8'h3C, 4'hC, 32'h0400_0000);
		acc(0, 8'h3C, 4'hF, 32'h0000_005A);
		fat = 1;
		run_disc(40, 2'b01);
		mask = 1;
		run_disc(40, 2'b00);
		acc(1, 8'h3C, 4'hC, 32'h0800_0000);
		mode = 0;
		run_disc(40, 2'b00);
		// clear the flag first so a wrongful drop would show; a repeated request must not be dropped
		acc(1, 8'h3C, 4'hC, 32'h0C00_0000);
		acc(0, 8'h3C, 4'hF, 32'h0800_005A);
		head = 1;
		repeat (5) @(negedge clk);
		rpt = 1;
		@(negedge clk);
		{rpt, head} = 2'b00;
		repeat (50) @(negedge clk);
		acc(0, 8'h3C, 4'hF, 32'h0800_005A);
		si = 4'hA;
		repeat (3) @(negedge clk);
		check(pi, 4'hA);
		summarize();
	end
endmodule
bind bcht_config_tail bcht_tail_monitor mon (.*);
`default_nettype wire
